/* logic/i2c_cmd_data_receiver.sv */
// two-wire write-only slave feeding commands and character ram
`timescale 1ns/1ps
`include "i2c_rx_regs.svh"
module i2c_cmd_data_receiver
  import i2c_rx_pkg::*;
(
  input  logic        aclk,            // 50 MHz system clock
  input  logic        aresetn,         // synchronous reset, active low
  input  logic        scl_in,          // serial clock level
  input  logic        sda_in,          // serial data level
  output logic        sda_out,         // data drive value, always 0
  output logic        sda_oe,          // low while pulling data low
  input  logic        addr_strap_low,  // address bit 0 strap
  input  logic        addr_strap_high, // address bit 1 strap
  output logic        busy_flag,       // high while initialising
  input  logic [5:0]  awaddr,          // axi write address
  input  logic        awvalid,         // write address valid
  output logic        awready,         // write address ready
  input  logic [31:0] wdata,           // write data
  input  logic [3:0]  wstrb,           // write byte enables
  input  logic        wvalid,          // write data valid
  output logic        wready,          // write data ready
  output logic [1:0]  bresp,           // write response
  output logic        bvalid,          // write response valid
  input  logic        bready,          // write response ready
  input  logic [5:0]  araddr,          // read address
  input  logic        arvalid,         // read address valid
  output logic        arready,         // read address ready
  output logic [31:0] rdata,           // read data
  output logic [1:0]  rresp,           // read response
  output logic        rvalid,          // read data valid
  input  logic        rready           // read data ready
);
  // ------------------------------------------------------------
  // line sampling and bus conditions
  // ------------------------------------------------------------
  logic        scl_q, sda_q;
  logic        scl_rise, scl_fall, start_det, stop_det;
  link_state_t state_q, state_d;
  byte_kind_t  kind_q, kind_d;
  logic [7:0]  shift_q, shift_d, byte_in;
  logic [2:0]  cnt_q, cnt_d;
  logic        last_q, last_d, sel_q, sel_d, oe_q, oe_d;
  logic        byte_done, addr_hit, data_exec;
  disp_set_t   set_q, set_d;
  logic [6:0]  ptr_q, ptr_d, fill_q, fill_d, ptr_step;
  logic        busy_q, busy_d;
  logic        ram_we;
  logic [6:0]  ram_addr;
  logic [7:0]  ram_wdata;
  logic [7:0]  char_ram [0:79];
  logic        enable_q, enable_d;
  logic [6:0]  ram_index_q, ram_index_d;

  // inputs are synchronous, so one stage of history is enough
  assign scl_rise  = scl_in & ~scl_q;
  assign scl_fall  = ~scl_in & scl_q;
  assign start_det = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_det  = scl_in & scl_q & ~sda_q & sda_in;
  assign byte_in   = {shift_q[6:0], sda_in};
  assign byte_done = (state_q == ST_RECV) && scl_rise && (cnt_q == 3'd7);
  assign addr_hit  = (byte_in[7:1] ==
                      {`ADDR_PREFIX, addr_strap_high, addr_strap_low});
  // data bytes arriving during initialisation are refused, not queued
  assign data_exec = byte_done && (kind_q == K_DATA) && !busy_q;

  // ------------------------------------------------------------
  // byte framing and acknowledge
  // ------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    kind_d  = kind_q;
    shift_d = shift_q;
    cnt_d   = cnt_q;
    last_d  = last_q;
    sel_d   = sel_q;
    oe_d    = oe_q;
    if (stop_det) begin
      state_d = ST_IDLE;
      oe_d    = 1'b1;
    end else if (start_det) begin
      // start, then address; repeated start also restarts
      state_d = ST_RECV;
      kind_d  = K_ADDR;
      cnt_d   = 3'd0;
      oe_d    = 1'b1;
    end else begin
      case (state_q)
        ST_RECV: begin
          if (scl_rise) begin
            shift_d = byte_in;
            cnt_d   = cnt_q + 3'd1;
          end
          if (byte_done) begin
            state_d = ST_ACK_WAIT;
            case (kind_q)
              K_ADDR: begin
                // only a write to the strapped address is acknowledged, and only while enabled
                if (addr_hit && !byte_in[0] && enable_q) begin
                  kind_d = K_CTRL;
                  last_d = 1'b0;
                end else begin
                  // other addresses: rest of transfer ignored
                  state_d = ST_IGNORE;
                end
              end
              K_CTRL: begin
                // control byte, then its data byte
                // msb clear marks the last control byte
                last_d = ~byte_in[7];
                // select bit governs following data bytes
                sel_d  = byte_in[6];
                kind_d = K_DATA;
              end
              default: begin
                // after the last control byte only data follows
                kind_d = last_q ? K_DATA : K_CTRL;
                if (busy_q) begin
                  state_d = ST_IGNORE;
                end
              end
            endcase
          end
        end
        ST_ACK_WAIT: begin
          // pull data low for the acknowledge clock
          if (scl_fall) begin
            oe_d    = 1'b0;
            state_d = ST_ACK;
          end
        end
        ST_ACK: begin
          if (scl_rise) begin
            state_d = ST_ACK_HOLD;
          end
        end
        ST_ACK_HOLD: begin
          if (scl_fall) begin
            oe_d    = 1'b1;
            state_d = ST_RECV;
            cnt_d   = 3'd0;
          end
        end
        ST_IDLE, ST_IGNORE: begin
          state_d = state_q;
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      state_q <= ST_IDLE;
      kind_q  <= K_ADDR;
      shift_q <= 8'h00;
      cnt_q   <= 3'd0;
      last_q  <= 1'b0;
      sel_q   <= 1'b0;
      oe_q    <= 1'b1;
    end else begin
      scl_q   <= scl_in;
      sda_q   <= sda_in;
      state_q <= state_d;
      kind_q  <= kind_d;
      shift_q <= shift_d;
      cnt_q   <= cnt_d;
      last_q  <= last_d;
      sel_q   <= sel_d;
      oe_q    <= oe_d;
    end
  end

  // ------------------------------------------------------------
  // display settings, pointer and initialisation
  // ------------------------------------------------------------
  // pointer wraps inside the 80 character locations
  assign ptr_step = set_q.addr_inc ?
                    ((ptr_q == `RAM_LAST) ? 7'd0 : ptr_q + 7'd1) :
                    ((ptr_q == 7'd0) ? `RAM_LAST : ptr_q - 7'd1);

  always_comb begin
    set_d  = set_q;
    ptr_d  = ptr_q;
    fill_d = fill_q;
    busy_d = busy_q;
    // busy until the last location has been filled
    if (busy_q) begin
      fill_d = fill_q + 7'd1;
      if (fill_q == `RAM_LAST) begin
        busy_d = 1'b0;
      end
    end else if (data_exec && sel_q) begin
      ptr_d = ptr_step;
    end else if (data_exec) begin
      casez (byte_in)
        8'b1???????: ptr_d = (byte_in[6:0] < `RAM_DEPTH) ?
                             byte_in[6:0] : 7'd0;
        8'b001?????: begin
          set_d.bus_width_sel = byte_in[4];
          set_d.two_lines     = byte_in[3];
          set_d.big_font      = byte_in[2];
        end
        8'b0001????: begin
          if (!byte_in[3]) begin
            ptr_d = byte_in[2] ?
                    ((ptr_q == `RAM_LAST) ? 7'd0 : ptr_q + 7'd1) :
                    ((ptr_q == 7'd0) ? `RAM_LAST : ptr_q - 7'd1);
          end
        end
        8'b00001???: begin
          set_d.disp_on   = byte_in[2];
          set_d.cursor_on = byte_in[1];
          set_d.blink_on  = byte_in[0];
        end
        8'b000001??: begin
          set_d.addr_inc   = byte_in[1];
          set_d.disp_shift = byte_in[0];
        end
        8'b0000001?: ptr_d = 7'd0;
        8'b00000001: begin
          // clear runs the same fill as power-on, busy meanwhile
          busy_d         = 1'b1;
          fill_d         = 7'd0;
          ptr_d          = 7'd0;
          set_d.addr_inc = 1'b1;
        end
        default: ptr_d = ptr_q;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // 8-bit width, one line, 5x8 font
      // display, cursor, blink off; increment, no shift
      set_q  <= '{bus_width_sel: 1'b1, addr_inc: 1'b1, default: 1'b0};
      ptr_q  <= 7'd0;
      fill_q <= 7'd0;
      busy_q <= 1'b1;
    end else begin
      set_q  <= set_d;
      ptr_q  <= ptr_d;
      fill_q <= fill_d;
      busy_q <= busy_d;
    end
  end

  // fill writes 20h at every location
  assign ram_we    = busy_q | (data_exec & sel_q);
  assign ram_addr  = busy_q ? fill_q : ptr_q;
  assign ram_wdata = busy_q ? `FILL_CHAR : byte_in;

  // character ram, no reset: initialisation writes it instead
  always_ff @(posedge aclk) begin
    if (ram_we) begin
      char_ram[ram_addr] <= ram_wdata;
    end
  end

  // ------------------------------------------------------------
  // axi4-lite register slave
  // ------------------------------------------------------------
  logic        aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [5:0]  aw_addr_q, aw_addr_d;
  logic [31:0] w_data_q, w_data_d, rdata_d;
  logic        w_strb0_q, w_strb0_d, bvalid_d, rvalid_d;
  logic [1:0]  bresp_d, rresp_d;

  always_comb begin
    aw_have_d   = aw_have_q;
    aw_addr_d   = aw_addr_q;
    w_have_d    = w_have_q;
    w_data_d    = w_data_q;
    w_strb0_d   = w_strb0_q;
    bvalid_d    = bvalid;
    bresp_d     = bresp;
    rvalid_d    = rvalid;
    rresp_d     = rresp;
    rdata_d     = rdata;
    enable_d    = enable_q;
    ram_index_d = ram_index_q;
    if (bvalid && bready) begin
      bvalid_d = 1'b0;
    end
    if (awvalid && awready) begin
      aw_have_d = 1'b1;
      aw_addr_d = awaddr;
    end
    if (wvalid && wready) begin
      w_have_d  = 1'b1;
      w_data_d  = wdata;
      w_strb0_d = wstrb[0];
    end
    // write goes once both halves are held and the response is free
    if (aw_have_q && w_have_q && !bvalid) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = `RESP_OKAY;
      case (aw_addr_q)
        `OFS_CTRL: if (w_strb0_q) enable_d = w_data_q[`CTRL_ENABLE_BIT];
        `OFS_RAM_INDEX: if (w_strb0_q) ram_index_d = w_data_q[6:0];
        `OFS_STATUS, `OFS_POINTER, `OFS_RAM_DATA: bresp_d = `RESP_OKAY;
        default: bresp_d = `RESP_SLVERR;
      endcase
    end
    if (rvalid && rready) begin
      rvalid_d = 1'b0;
    end
    if (arvalid && arready) begin
      rvalid_d = 1'b1;
      rresp_d  = `RESP_OKAY;
      case (araddr)
        `OFS_CTRL:      rdata_d = {31'h0, enable_q};
        `OFS_STATUS:    rdata_d = {23'h0, set_q, busy_q};
        `OFS_POINTER:   rdata_d = {25'h0, ptr_q};
        `OFS_RAM_INDEX: rdata_d = {25'h0, ram_index_q};
        `OFS_RAM_DATA:  rdata_d = (ram_index_q < `RAM_DEPTH) ?
                                  {24'h0, char_ram[ram_index_q]} : 32'h0;
        default: begin
          rdata_d = 32'h0;
          rresp_d = `RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q   <= 1'b0;
      aw_addr_q   <= 6'h00;
      w_have_q    <= 1'b0;
      w_data_q    <= 32'h0;
      w_strb0_q   <= 1'b0;
      awready     <= 1'b0;
      wready      <= 1'b0;
      bvalid      <= 1'b0;
      bresp       <= `RESP_OKAY;
      arready     <= 1'b0;
      rvalid      <= 1'b0;
      rresp       <= `RESP_OKAY;
      rdata       <= 32'h0;
      enable_q    <= `CTRL_RESET;
      ram_index_q <= 7'd0;
      sda_out     <= 1'b0;
      sda_oe      <= 1'b1;
      busy_flag   <= 1'b1;
    end else begin
      aw_have_q   <= aw_have_d;
      aw_addr_q   <= aw_addr_d;
      w_have_q    <= w_have_d;
      w_data_q    <= w_data_d;
      w_strb0_q   <= w_strb0_d;
      awready     <= !aw_have_d;
      wready      <= !w_have_d;
      bvalid      <= bvalid_d;
      bresp       <= bresp_d;
      arready     <= !rvalid_d;
      rvalid      <= rvalid_d;
      rresp       <= rresp_d;
      rdata       <= rdata_d;
      enable_q    <= enable_d;
      ram_index_q <= ram_index_d;
      sda_out     <= 1'b0;
      sda_oe      <= oe_d;
      busy_flag   <= busy_d;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_addr_end;
    byte_done && kind_q == K_ADDR;
  endsequence
  sequence s_ack_start;
    state_q == ST_ACK_WAIT && scl_fall && !stop_det && !start_det;
  endsequence

  chk_addr_match: assert property (
    s_addr_end and (addr_hit && !byte_in[0] && enable_q && !stop_det)
    |=> state_q == ST_ACK_WAIT && kind_q == K_CTRL)
    else $error("matching address not taken");
  chk_read_nack: assert property (
    s_addr_end and byte_in[0] |=> state_q == ST_IGNORE)
    else $error("read address was accepted");
  chk_ignore_quiet: assert property (
    state_q == ST_IGNORE |-> sda_oe)
    else $error("data line driven while ignoring");
  chk_ctrl_data: assert property (
    byte_done && kind_q == K_CTRL && !byte_in[7] |=> kind_q == K_DATA ##0
    last_q)
    else $error("last control byte not recorded");
  chk_last_ctrl: assert property (
    byte_done && kind_q == K_DATA && last_q |=> kind_q == K_DATA)
    else $error("control byte expected after last one");
  chk_ram_advance: assert property (
    data_exec && sel_q && set_q.addr_inc && ptr_q < `RAM_LAST
    |=> ptr_q == $past(ptr_q) + 7'd1)
    else $error("pointer did not advance");
  chk_cmd_display: assert property (
    data_exec && !sel_q && byte_in[7:3] == 5'b00001
    |=> set_q.disp_on == $past(byte_in[2]))
    else $error("display command not applied");
  chk_ack_low: assert property (
    s_ack_start |=> !sda_oe ##1 !sda_oe)
    else $error("acknowledge not driven");
  chk_busy_hold: assert property (
    busy_q && fill_q != `RAM_LAST |=> busy_flag && busy_q)
    else $error("busy dropped before fill ended");
  chk_fill_char: assert property (
    busy_q |=> char_ram[$past(fill_q)] == `FILL_CHAR)
    else $error("fill value wrong");
  chk_stop_abort: assert property (
    stop_det |=> state_q == ST_IDLE && sda_oe)
    else $error("stop did not end parsing");
endmodule : i2c_cmd_data_receiver

/* logic/i2c_rx_regs.svh */
// offsets, field positions, reset values and counts of the serial receiver
`ifndef I2C_RX_REGS_SVH
`define I2C_RX_REGS_SVH
`define OFS_CTRL        6'h00
`define OFS_STATUS      6'h04
`define OFS_POINTER     6'h08
`define OFS_RAM_INDEX   6'h0c
`define OFS_RAM_DATA    6'h10
`define CTRL_ENABLE_BIT 0
`define CTRL_RESET      1'b1
`define ADDR_PREFIX     5'b01111
`define RAM_DEPTH       7'd80
`define RAM_LAST        7'd79
`define FILL_CHAR       8'h20
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10
`endif

/* logic/i2c_rx_pkg.sv */
// types shared by the serial command and data receiver
package i2c_rx_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_RECV, ST_ACK_WAIT, ST_ACK, ST_ACK_HOLD, ST_IGNORE
  } link_state_t;
  typedef enum logic [1:0] { K_ADDR, K_CTRL, K_DATA } byte_kind_t;
  typedef struct packed {
    logic bus_width_sel; // 1 = 8-bit
    logic two_lines;
    logic big_font;
    logic disp_on;
    logic cursor_on;
    logic blink_on;
    logic addr_inc;
    logic disp_shift;
  } disp_set_t;
endpackage : i2c_rx_pkg

/* tb/i2c_master_model.sv */
// two-wire bus master model that feeds bytes to the receiver
`timescale 1ns/1ps
module i2c_master_model (
  input  wire logic aclk,     // pacing clock
  input  wire logic sda_wire, // resolved data line
  output logic      scl,      // serial clock, idle high
  output logic      sda_low   // high while the master pulls data low
);
  // ---------------------------------------------
  // line phases
  // ---------------------------------------------
  localparam int HOLD = 4;

  // idle bus: both lines released to the pull-ups
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // one phase; lines change after an edge and stand for HOLD + 1 cycles
  task automatic step(input logic c, input logic l);
    @(posedge aclk);
    scl     <= c;
    sda_low <= l;
    repeat (HOLD) @(posedge aclk);
  endtask : step

  // start condition
  // data is released only while scl is low, so no stray stop is seen
  task automatic start_cond();
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
  endtask : start_cond

  // stop once the last byte is through
  task automatic stop_cond();
    step(1'b0, sda_low);
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
  endtask : stop_cond

  // bytes go msb first, then a released acknowledge slot
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      step(1'b0, sda_low);
      step(1'b0, !b[i]);
      step(1'b1, !b[i]);
    end
    step(1'b0, sda_low);
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    ack = !sda_wire;
  endtask : send_byte
endmodule : i2c_master_model

/* tb/i2c_cmd_data_receiver_tb.sv */
// self-checking bench for the two-wire command and data receiver
`timescale 1ns/1ps
`include "i2c_rx_regs.svh"
module i2c_cmd_data_receiver_tb;
  // ---------------------------------------------
  // signals and instances
  // ---------------------------------------------
  logic        aclk, aresetn, scl_in, m_low, sda_out, sda_oe, busy_flag;
  logic        addr_strap_low, addr_strap_high;
  logic [5:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp, r;
  int          errors, check_count, n;
  // pull-up wire: low when either party pulls it
  wire         sda_in = m_low ? 1'b0 : (sda_oe ? 1'b1 : sda_out);

  i2c_cmd_data_receiver i2c_cmd_data_receiver_inst (
    .aclk, .aresetn, .scl_in, .sda_in, .sda_out, .sda_oe,
    .addr_strap_low, .addr_strap_high, .busy_flag,
    .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready);

  i2c_master_model i2c_master_model_inst (
    .aclk(aclk), .sda_wire(sda_in), .scl(scl_in), .sda_low(m_low));

  // 50 MHz clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  typedef struct packed {
    logic        wr;
    logic [5:0]  a;
    logic [31:0] d;
    logic [1:0]  resp;
  } row_t;
  // register rows: data is write value or expected read value
  row_t rows [9] = '{
    '{1'b0, `OFS_STATUS, 32'h104, `RESP_OKAY},
    '{1'b0, `OFS_POINTER, 32'h0, `RESP_OKAY},
    '{1'b0, `OFS_CTRL, 32'h1, `RESP_OKAY},
    '{1'b1, `OFS_RAM_INDEX, 32'h4f, `RESP_OKAY},
    '{1'b0, `OFS_RAM_INDEX, 32'h4f, `RESP_OKAY},
    '{1'b1, `OFS_STATUS, 32'hff, `RESP_OKAY},
    '{1'b0, `OFS_STATUS, 32'h104, `RESP_OKAY},
    '{1'b1, 6'h14, 32'h0, `RESP_SLVERR},
    '{1'b0, 6'h14, 32'h0, `RESP_SLVERR}};

  // ---------------------------------------------
  // checking and bus tasks
  // ---------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  // a wait that ran out ends the run
  task automatic hung();
    errors++;
    $display("[FAIL] %0t wait ran out", $time);
    close_out();
  endtask : hung

  task automatic chk(input logic [31:0] got, exp, input string m);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, m, got, exp);
    end
  endtask : chk

  // address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [5:0] a, input logic [31:0] v,
                        output logic [1:0] rs);
    logic aok, wok;
    aok = 1'b0;
    wok = 1'b0;
    n = 0;
    awaddr  <= a;
    wdata   <= v;
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(aok && wok)) begin
      @(posedge aclk);
      if (!aok && awready) begin
        aok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wok && wready) begin
        wok = 1'b1;
        wvalid <= 1'b0;
      end
      if (n++ > 200) hung();
    end
    do begin
      @(posedge aclk);
      if (n++ > 400) hung();
    end while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
    // one edge between calls, so no strobe is driven twice in a step
    @(posedge aclk);
  endtask : axi_wr

  task automatic axi_rd(input logic [5:0] a, output logic [31:0] v,
                        output logic [1:0] rs);
    n = 0;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (n++ > 200) hung();
    end while (!arready);
    arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      if (n++ > 400) hung();
    end while (!rvalid);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
    // back-to-back reads would otherwise drop and raise rready at once
    @(posedge aclk);
  endtask : axi_rd

  task automatic reg_chk(input logic [5:0] a, input logic [31:0] e);
    axi_rd(a, d, r);
    chk(d, e, "register value");
  endtask : reg_chk

  task automatic ram_chk(input logic [6:0] i, input logic [7:0] e);
    axi_wr(`OFS_RAM_INDEX, {25'h0, i}, r);
    reg_chk(`OFS_RAM_DATA, {24'h0, e});
  endtask : ram_chk

  // one serial byte and its expected acknowledge
  task automatic sb(input logic [7:0] b, input logic e);
    logic ack;
    i2c_master_model_inst.send_byte(b, ack);
    chk(ack, e, "acknowledge");
  endtask : sb

  function automatic logic [7:0] adr(input logic rw);
    return {`ADDR_PREFIX, addr_strap_high, addr_strap_low, rw};
  endfunction : adr

  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    {aresetn, addr_strap_low, addr_strap_high} = 3'b000;
    {awvalid, wvalid, bready, arvalid, rready} = 5'b00000;
    {awaddr, araddr, wdata, wstrb} = '0;
    errors = 0;
    check_count = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(busy_flag, 1'b1, "busy after reset");
    n = 0;
    while (busy_flag !== 1'b0) begin
      @(posedge aclk);
      if (n++ > 300) hung();
    end
    for (int i = 0; i < `RAM_DEPTH; i++) ram_chk(7'(i), `FILL_CHAR);
    $display("power-on fill done");
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        axi_wr(rows[i].a, rows[i].d, r);
      end else begin
        axi_rd(rows[i].a, d, r);
        chk(d, rows[i].d, "row data");
      end
      chk(r, rows[i].resp, "row response");
    end
    $display("register rows done");
    // every strap setting; a flipped low bit must be ignored
    for (int s = 0; s < 4; s++) begin
      addr_strap_low  <= s[0];
      addr_strap_high <= s[1];
      @(posedge aclk);
      i2c_master_model_inst.start_cond();
      sb(adr(1'b0), 1'b1);
      i2c_master_model_inst.stop_cond();
      i2c_master_model_inst.start_cond();
      sb(adr(1'b0) ^ 8'h02, 1'b0);
      i2c_master_model_inst.stop_cond();
    end
    $display("address straps done");
    i2c_master_model_inst.start_cond();
    sb(adr(1'b1), 1'b0);
    sb(8'h40, 1'b0);
    sb(8'h41, 1'b0);
    i2c_master_model_inst.stop_cond();
    reg_chk(`OFS_POINTER, 32'h0);
    $display("read refusal done");
    i2c_master_model_inst.start_cond();
    sb(adr(1'b0), 1'b1);
    sb(8'h40, 1'b1);
    sb(8'h41, 1'b1);
    sb(8'h42, 1'b1);
    i2c_master_model_inst.stop_cond();
    reg_chk(`OFS_POINTER, 32'h2);
    ram_chk(7'h0, 8'h41);
    ram_chk(7'h1, 8'h42);
    $display("ram data done");
    // command words, then commands whose msb looks like a control byte
    i2c_master_model_inst.start_cond();
    sb(adr(1'b0), 1'b1);
    sb(8'h80, 1'b1);
    sb(8'h0f, 1'b1);
    sb(8'hc0, 1'b1);
    sb(8'h5a, 1'b1);
    sb(8'h00, 1'b1);
    sb(8'h85, 1'b1);
    sb(8'h38, 1'b1);
    sb(8'hc1, 1'b1);
    i2c_master_model_inst.stop_cond();
    reg_chk(`OFS_STATUS, 32'h1bc);
    reg_chk(`OFS_POINTER, 32'h41);
    ram_chk(7'h2, 8'h5a);
    $display("commands done");
    i2c_master_model_inst.start_cond();
    sb(adr(1'b0), 1'b1);
    sb(8'h40, 1'b1);
    sb(8'h58, 1'b1);
    i2c_master_model_inst.start_cond();
    sb(adr(1'b0), 1'b1);
    sb(8'h40, 1'b1);
    sb(8'h59, 1'b1);
    i2c_master_model_inst.stop_cond();
    reg_chk(`OFS_POINTER, 32'h43);
    ram_chk(7'h41, 8'h58);
    ram_chk(7'h42, 8'h59);
    $display("repeated start done");
    // entry decrement, cursor left, pointer past the end, wrap below 0
    i2c_master_model_inst.start_cond();
    sb(adr(1'b0), 1'b1);
    sb(8'h80, 1'b1);
    sb(8'h04, 1'b1);
    sb(8'h80, 1'b1);
    sb(8'h10, 1'b1);
    reg_chk(`OFS_POINTER, 32'h42);
    sb(8'h80, 1'b1);
    sb(8'hd0, 1'b1);
    sb(8'h40, 1'b1);
    sb(8'h5b, 1'b1);
    i2c_master_model_inst.stop_cond();
    reg_chk(`OFS_POINTER, 32'h4f);
    reg_chk(`OFS_STATUS, 32'h1b8);
    ram_chk(7'h0, 8'h5b);
    $display("entry and cursor commands done");
    i2c_master_model_inst.start_cond();
    sb(adr(1'b0), 1'b1);
    sb(8'h00, 1'b1);
    sb(8'h02, 1'b1);
    reg_chk(`OFS_POINTER, 32'h0);
    sb(8'h01, 1'b1);
    chk(busy_flag, 1'b1, "busy on clear");
    i2c_master_model_inst.stop_cond();
    n = 0;
    while (busy_flag !== 1'b0) begin
      @(posedge aclk);
      if (n++ > 300) hung();
    end
    reg_chk(`OFS_POINTER, 32'h0);
    ram_chk(7'h41, `FILL_CHAR);
    reg_chk(`OFS_STATUS, 32'h1bc);
    $display("clear command done");
    axi_wr(`OFS_CTRL, 32'h0, r);
    i2c_master_model_inst.start_cond();
    sb(adr(1'b0), 1'b0);
    i2c_master_model_inst.stop_cond();
    axi_wr(`OFS_CTRL, 32'h1, r);
    i2c_master_model_inst.start_cond();
    sb(adr(1'b0), 1'b1);
    sb(8'h40, 1'b1);
    sb(8'h33, 1'b1);
    i2c_master_model_inst.stop_cond();
    ram_chk(7'h0, 8'h33);
    $display("slave enable done");
    // second reset must undo settings, enable and ram contents
    axi_wr(`OFS_CTRL, 32'h0, r);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(busy_flag, 1'b1, "busy after second reset");
    n = 0;
    while (busy_flag !== 1'b0) begin
      @(posedge aclk);
      if (n++ > 300) hung();
    end
    reg_chk(`OFS_CTRL, 32'h1);
    reg_chk(`OFS_STATUS, 32'h104);
    reg_chk(`OFS_POINTER, 32'h0);
    ram_chk(7'h0, `FILL_CHAR);
    $display("second reset done");
    close_out();
  end
endmodule : i2c_cmd_data_receiver_tb
